// ==== rtl/sdt_ctrl.sv ====
`timescale 1ns/100ps
// Operation
// R01: Time limits become counts, rounded safely
// R02: Device accepts rounded-up command spacing
// R03: Dll off read window one earlier
// R04: Reads wait exit delay, also after latency change
// R05: Auto precharge held until row time
// R06: Dll off recovery: four cycles or 15ns
// R07: Recovery starts four, fixed chop two
// R08: Refresh interval follows temperature range
// R09: Nine refreshes within every window
// R10: Power-down only after refresh delay
// R11: At least one idle after refresh
// R12: Slow clock: precharge all after refresh
// R13: Device reset held low from start
// R14: Spread row addresses across the array
// R15: Power-down exit waits before reads
// R16: Timing limits held as cycle counts
module sdt_ctrl
   import sdt_pkg::*;
#(
   parameter int RESET_HOLD = RESET_HOLD_CYC,
   parameter int REF_WINDOW = REF_WINDOW_CYC
) (
   // Clock and reset
   input  wire logic              SYS_CLK,
   input  wire logic              SYS_RST,
   // Access requests
   input  wire logic              REQ_VALID,
   output logic                   REQ_READY,
   input  wire logic              REQ_WRITE,
   input  wire logic              REQ_AUTO_PRE,
   input  wire logic              REQ_OTF_CHOP,
   input  wire logic [BANK_W-1:0] REQ_BANK,
   input  wire logic [ROW_W-1:0]  REQ_ROW,
   // Mode and environment
   input  wire logic              MODE_VALID,
   input  wire logic [ROW_W-1:0]  MODE_WORD,
   input  wire logic [1:0]        TEMP_RANGE,
   input  wire logic              PD_REQ,
   output logic                   PD_ACTIVE,
   // Read data
   output logic                   RD_VALID,
   output logic [DQ_W-1:0]        RD_DATA,
   // Command link
   sdt_if.ctrl                    mem
);

   // ****************************************
   // Derived limits
   // ****************************************
   // R09: postponement bound from the window
   localparam int LIM_85  = REF_WINDOW / REFI_85_CYC - 1;
   localparam int LIM_95  = REF_WINDOW / REFI_95_CYC - 1;
   localparam int LIM_105 = REF_WINDOW / REFI_105_CYC - 1;
   // R10: some entries also need the exit delay
   localparam int PDEN_CYC = (XPDLL_CYC > REFPDEN_MIN_CK) ? XPDLL_CYC : REFPDEN_MIN_CK;

   typedef enum logic [3:0] {
      ST_RESET  = 4'h0,
      ST_IDLE   = 4'h1,
      ST_ACT    = 4'h2,
      ST_XFER   = 4'h3,
      ST_CLOSE  = 4'h4,
      ST_REF    = 4'h5,
      ST_PD     = 4'h6
   } sdt_state_e;

   sdt_state_e          state,    next_state;
   sdt_cmd_e            cmd,      next_cmd;
   logic [BANK_W-1:0]   bank,     next_bank;
   logic [ROW_W-1:0]    row,      next_row;
   logic                cke,      next_cke;
   logic                rst_n,    next_rst_n;
   logic                chop,     next_chop;
   logic                is_wr,    next_is_wr;
   logic                is_ap,    next_is_ap;
   logic [19:0]         wait_cnt, next_wait_cnt;
   logic [7:0]          dll_wait, next_dll_wait;
   logic [7:0]          pden,     next_pden;
   logic [15:0]         refi,     next_refi;
   logic [3:0]          owed,     next_owed;
   logic [ROW_W-1:0]    mode,     next_mode;
   logic                mode_pend, next_mode_pend;
   logic [ROW_W-1:0]    mode_new, next_mode_new;
   logic                rd_valid, next_rd_valid;
   logic [DQ_W-1:0]     rd_data,  next_rd_data;
   logic [15:0]         refi_sel;
   logic [3:0]          owe_lim;
   logic                must_ref;
   logic                accept;
   logic                ref_go;

   // R08: interval picked by temperature range
   // Owed count capped below the nine-refresh burst
   always_comb begin
      if (TEMP_RANGE == TEMP_105) begin
         refi_sel = 16'(REFI_105_CYC);
         owe_lim  = 4'((LIM_105 < REF_BURST) ? LIM_105 : REF_BURST - 1);
      end else if (TEMP_RANGE == TEMP_95) begin
         refi_sel = 16'(REFI_95_CYC);
         owe_lim  = 4'((LIM_95 < REF_BURST) ? LIM_95 : REF_BURST - 1);
      end else begin
         refi_sel = 16'(REFI_85_CYC);
         owe_lim  = 4'((LIM_85 < REF_BURST) ? LIM_85 : REF_BURST - 1);
      end
   end

   assign must_ref  = (owed >= owe_lim);
   // R04: reads blocked until exit delay done
   assign REQ_READY = (state == ST_IDLE) && !must_ref && !mode_pend && (REQ_WRITE || dll_wait == 8'h0);
   assign accept    = REQ_VALID && REQ_READY;
   assign ref_go    = (state == ST_IDLE) && !accept && !mode_pend && (owed != 4'h0);

   // ****************************************
   // Sequencer
   // ****************************************
   always_comb begin
      next_state     = state;
      next_cmd       = CMD_NOP;
      next_bank      = bank;
      next_row       = row;
      next_cke       = cke;
      next_rst_n     = rst_n;
      next_chop      = chop;
      next_is_wr     = is_wr;
      next_is_ap     = is_ap;
      next_wait_cnt  = (wait_cnt != 20'h0) ? wait_cnt - 20'h1 : wait_cnt;
      next_dll_wait  = (dll_wait != 8'h0) ? dll_wait - 8'h1 : dll_wait;
      next_pden      = (pden != 8'h0) ? pden - 8'h1 : pden;
      next_refi      = refi - 16'h1;
      next_owed      = owed;
      next_mode      = mode;
      next_mode_pend = mode_pend || MODE_VALID;
      next_mode_new  = MODE_VALID ? MODE_WORD : mode_new;
      next_rd_valid  = mem.dq_dev_oe;
      next_rd_data   = mem.dq_dev_oe ? mem.dq_dev : rd_data;
      // R16: interval counted in own clock
      if (refi == 16'h0) begin
         next_refi = refi_sel - 16'h1;
      end
      case (state)
         ST_RESET: begin
            if (wait_cnt == 20'h0) begin
               next_rst_n    = 1'b1;
               next_cke      = 1'b1;
               next_cmd      = CMD_MODE_SET;
               next_row      = mode;
               next_dll_wait = 8'(XPDLL_CYC);
               next_state    = ST_IDLE;
            end
         end
         ST_IDLE: begin
            if (must_ref) begin
               // R09: postponed refreshes forced out
               next_cmd      = CMD_REFRESH;
               next_wait_cnt = 20'(RFC_CYC - 1);
               next_pden     = 8'(PDEN_CYC);
               next_state    = ST_REF;
            end else if (mode_pend) begin
               next_cmd       = CMD_MODE_SET;
               next_row       = mode_new;
               next_mode      = mode_new;
               next_mode_pend = MODE_VALID;
               // R04: latency change restarts exit delay
               next_dll_wait  = 8'(XPDLL_CYC);
            end else if (accept) begin
               next_cmd      = CMD_ACTIVATE;
               next_bank     = REQ_BANK;
               // R14: bank-keyed row spreading
               next_row      = REQ_ROW ^ (ROW_W'(REQ_BANK) << (ROW_W - BANK_W));
               next_is_wr    = REQ_WRITE;
               next_is_ap    = REQ_AUTO_PRE;
               next_chop     = REQ_OTF_CHOP;
               next_wait_cnt = 20'(RCD_CYC - 1);
               next_state    = ST_ACT;
            end else if (ref_go) begin
               next_cmd      = CMD_REFRESH;
               next_wait_cnt = 20'(RFC_CYC - 1);
               next_pden     = 8'(PDEN_CYC);
               next_state    = ST_REF;
            end else if (PD_REQ && pden == 8'h0) begin
               // R10: clock enable drops after refresh delay
               next_cke   = 1'b0;
               next_state = ST_PD;
            end
         end
         ST_ACT: begin
            if (wait_cnt == 20'h0) begin
               next_cmd   = is_wr ? (is_ap ? CMD_WRITE_AP : CMD_WRITE) : (is_ap ? CMD_READ_AP : CMD_READ);
               next_row   = row;
               next_state = ST_XFER;
               // R07: wait covers recovery after latency
               next_wait_cnt = 20'(RAS_CYC) + 20'(mode[MF_WL_LSB +: 4]) + 20'(WR_START_FULL)
                             + 20'(WR_DLL_OFF_CYC) + 20'(mode[MF_RL_LSB +: 4]) + 20'(mode[MF_AL_LSB +: 3]);
            end
         end
         ST_XFER: begin
            if (wait_cnt == 20'h0) begin
               // R05: device closes row itself with auto precharge
               if (!is_ap) begin
                  next_cmd = CMD_PRECHARGE;
               end
               next_wait_cnt = 20'(RP_CYC - 1);
               next_state    = ST_CLOSE;
            end
         end
         ST_CLOSE: begin
            if (wait_cnt == 20'h0) begin
               next_state = ST_IDLE;
            end
         end
         ST_REF: begin
            // R11: refresh cycle time filled with idles
            if (wait_cnt == 20'h0) begin
               if (SLOW_CLK) begin
                  // R12: slow clock closes all banks
                  next_cmd      = CMD_PRECHARGE_ALL;
                  next_wait_cnt = 20'(RP_CYC - 1);
                  next_state    = ST_CLOSE;
               end else begin
                  next_state = ST_IDLE;
               end
            end
         end
         ST_PD: begin
            if (!PD_REQ || must_ref) begin
               next_cke      = 1'b1;
               // R15: exit delay before locked-clock reads
               next_dll_wait = 8'(XPDLL_CYC);
               next_state    = ST_IDLE;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
      // Count and refresh in one cycle cancel, so no tick is lost
      if (refi == 16'h0 && next_cmd != CMD_REFRESH) begin
         next_owed = (owed == 4'hF) ? owed : owed + 4'h1;
      end else if (refi != 16'h0 && next_cmd == CMD_REFRESH) begin
         next_owed = owed - 4'h1;
      end
      if (SYS_RST) begin
         next_state     = ST_RESET;
         next_cmd       = CMD_NOP;
         next_bank      = '0;
         next_row       = '0;
         // R13: device reset low from the start
         next_rst_n     = 1'b0;
         next_cke       = 1'b0;
         next_chop      = 1'b0;
         next_is_wr     = 1'b0;
         next_is_ap     = 1'b0;
         next_wait_cnt  = 20'(RESET_HOLD - 1);
         next_dll_wait  = 8'h0;
         next_pden      = 8'h0;
         next_refi      = 16'(REFI_85_CYC - 1);
         next_owed      = 4'h0;
         next_mode      = MODE_RESET;
         next_mode_pend = 1'b0;
         next_mode_new  = MODE_RESET;
         next_rd_valid  = 1'b0;
         next_rd_data   = 8'h00;
      end
   end

   always_ff @(posedge SYS_CLK) begin
      state     <= next_state;
      cmd       <= next_cmd;
      bank      <= next_bank;
      row       <= next_row;
      cke       <= next_cke;
      rst_n     <= next_rst_n;
      chop      <= next_chop;
      is_wr     <= next_is_wr;
      is_ap     <= next_is_ap;
      wait_cnt  <= next_wait_cnt;
      dll_wait  <= next_dll_wait;
      pden      <= next_pden;
      refi      <= next_refi;
      owed      <= next_owed;
      mode      <= next_mode;
      mode_pend <= next_mode_pend;
      mode_new  <= next_mode_new;
      rd_valid  <= next_rd_valid;
      rd_data   <= next_rd_data;
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign mem.cmd      = cmd;
   assign mem.bank     = bank;
   assign mem.row      = row;
   assign mem.cke      = cke;
   assign mem.reset_n  = rst_n;
   assign mem.otf_chop = chop;
   assign PD_ACTIVE    = (state == ST_PD);
   assign RD_VALID     = rd_valid;
   assign RD_DATA      = rd_data;

endmodule : sdt_ctrl

// ==== rtl/sdt_dev.sv ====
`timescale 1ns/100ps
module sdt_dev
   import sdt_pkg::*;
#(
   parameter int BANKS = 8
) (
   // Clock and reset
   input  wire logic             SYS_CLK,
   input  wire logic             SYS_RST,
   // Command link
   sdt_if.dev                    mem,
   // Status
   output logic [BANKS-1:0]      BANK_OPEN,
   output logic                  RD_WINDOW,
   output logic                  AUTO_PRE,
   output logic                  TIMING_ERR
);

   // ****************************************
   // Mode and read pipe
   // ****************************************
   logic                rst;
   logic                cmd_ok;
   logic [ROW_W-1:0]    mode,    next_mode;
   logic [31:0]         rd_sr,   next_rd_sr;
   logic [DQ_W-1:0]     dq_cnt,  next_dq_cnt;
   logic [5:0]          rd_dly;
   logic [5:0]          wr_lat;
   logic [5:0]          wr_cyc;
   logic [BANKS-1:0]    pre_pulse, bank_err;
   logic                err,     next_err;

   // Device reset pin clears all state; outputs stay off
   assign rst    = SYS_RST || !mem.reset_n;
   assign cmd_ok = mem.cke;

   always_comb begin
      next_mode   = mode;
      next_dq_cnt = dq_cnt;
      rd_dly      = 6'(mode[MF_RL_LSB +: 4]) + 6'(mode[MF_AL_LSB +: 3]);
      // R03: dll off reads one earlier
      if (mode[MF_DLL_OFF] && rd_dly > 6'h1) begin
         rd_dly = rd_dly - 6'h1;
      end
      if (rd_dly == 6'h0) begin
         rd_dly = 6'h1;
      end
      next_rd_sr = rd_sr >> 1;
      if (cmd_ok && (mem.cmd == CMD_READ || mem.cmd == CMD_READ_AP)) begin
         next_rd_sr = next_rd_sr | (32'h1 << (rd_dly - 6'h1));
      end
      if (cmd_ok && mem.cmd == CMD_MODE_SET) begin
         next_mode = mem.row;
      end
      if (rd_sr[0]) begin
         next_dq_cnt = dq_cnt + 8'h01;
      end
      next_err = err || (|bank_err);
      if (rst) begin
         next_mode   = MODE_RESET;
         next_rd_sr  = 32'h0;
         next_dq_cnt = 8'h00;
         next_err    = 1'b0;
      end
   end

   always_ff @(posedge SYS_CLK) begin
      mode   <= next_mode;
      rd_sr  <= next_rd_sr;
      dq_cnt <= next_dq_cnt;
      err    <= next_err;
   end

   assign wr_lat = 6'(mode[MF_WL_LSB +: 4]);
   // R06: dll off recovery is the larger figure
   assign wr_cyc = mode[MF_DLL_OFF] ? 6'(WR_DLL_OFF_CYC) : 6'(WR_CYC);

   // ****************************************
   // Per-bank row timing
   // ****************************************
   for (genvar b = 0; b < BANKS; b++) begin : g_bank
      logic       open, next_open;
      logic       ap,   next_ap;
      logic [7:0] ras,  next_ras;
      logic [7:0] wrc,  next_wrc;
      logic       next_pulse;
      logic       hit;

      always_comb begin
         // Idle cycles on the link are not traffic to this bank
         hit         = cmd_ok && (mem.cmd != CMD_NOP) && (mem.bank == BANK_W'(b));
         next_open   = open;
         next_ap     = ap;
         next_ras    = (ras != 8'h0) ? ras - 8'h1 : ras;
         next_wrc    = (wrc != 8'h0) ? wrc - 8'h1 : wrc;
         next_pulse  = 1'b0;
         bank_err[b] = 1'b0;
         if (hit && mem.cmd == CMD_ACTIVATE) begin
            bank_err[b] = open;
            next_open   = 1'b1;
            // R02: exact rounded count is accepted
            next_ras    = 8'(RAS_CYC - 1);
         end
         if (hit && (mem.cmd == CMD_READ_AP || mem.cmd == CMD_WRITE_AP)) begin
            next_ap = 1'b1;
         end
         if (hit && (mem.cmd == CMD_WRITE || mem.cmd == CMD_WRITE_AP)) begin
            // R07: recovery start after write latency
            if (mode[MF_CHOP_FIXED]) begin
               next_wrc = 8'(wr_lat) + 8'(WR_START_CHOP) + 8'(wr_cyc) - 8'h1;
            end else begin
               next_wrc = 8'(wr_lat) + 8'(WR_START_FULL) + 8'(wr_cyc) - 8'h1;
            end
         end
         if ((hit && mem.cmd == CMD_PRECHARGE) || (cmd_ok && mem.cmd == CMD_PRECHARGE_ALL)) begin
            bank_err[b] = open && (ras != 8'h0);
            next_open   = 1'b0;
            next_ap     = 1'b0;
         end
         // R05: internal precharge waits for row time
         if (ap && ras == 8'h0 && wrc == 8'h0 && !hit) begin
            next_open  = 1'b0;
            next_ap    = 1'b0;
            next_pulse = 1'b1;
         end
         if (rst) begin
            next_open  = 1'b0;
            next_ap    = 1'b0;
            next_ras   = 8'h0;
            next_wrc   = 8'h0;
            next_pulse = 1'b0;
         end
      end

      always_ff @(posedge SYS_CLK) begin
         open         <= next_open;
         ap           <= next_ap;
         ras          <= next_ras;
         wrc          <= next_wrc;
         pre_pulse[b] <= next_pulse;
      end

      assign BANK_OPEN[b] = open;
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign RD_WINDOW     = rd_sr[0];
   assign AUTO_PRE      = |pre_pulse;
   assign TIMING_ERR    = err;
   assign mem.dq_dev_oe = rd_sr[0];
   assign mem.dq_dev    = dq_cnt;

endmodule : sdt_dev

// ==== rtl/sdt_if.sv ====
`timescale 1ns/100ps
interface sdt_if;
   import sdt_pkg::*;

   sdt_cmd_e           cmd;
   logic [BANK_W-1:0]  bank;
   logic [ROW_W-1:0]   row;
   logic               cke;
   logic               reset_n;
   logic               otf_chop;
   logic [DQ_W-1:0]    dq_dev;
   logic               dq_dev_oe;

   modport ctrl (output cmd, bank, row, cke, reset_n, otf_chop, input dq_dev, dq_dev_oe);
   modport dev  (input cmd, bank, row, cke, reset_n, otf_chop, output dq_dev, dq_dev_oe);
endinterface : sdt_if

// ==== rtl/sdt_pkg.sv ====
package sdt_pkg;

   // ****************************************
   // Clock and conversion
   // ****************************************
   localparam int CLK_PS = 5000;

   // R01: minimum rounds up
   function automatic int cyc_min(longint ps);
      longint c;
      c = (ps + CLK_PS - 1) / CLK_PS;
      return (c < 1) ? 1 : int'(c);
   endfunction : cyc_min

   // R01: maximum rounds down
   function automatic int cyc_max(longint ps);
      longint c;
      c = ps / CLK_PS;
      return (c < 1) ? 1 : int'(c);
   endfunction : cyc_max

   // ****************************************
   // Widths and commands
   // ****************************************
   localparam int ROW_W  = 14;
   localparam int BANK_W = 3;
   localparam int DQ_W   = 8;

   typedef enum logic [3:0] {
      CMD_NOP           = 4'h0,
      CMD_ACTIVATE      = 4'h1,
      CMD_READ          = 4'h2,
      CMD_READ_AP       = 4'h3,
      CMD_WRITE         = 4'h4,
      CMD_WRITE_AP      = 4'h5,
      CMD_PRECHARGE     = 4'h6,
      CMD_PRECHARGE_ALL = 4'h7,
      CMD_REFRESH       = 4'h8,
      CMD_MODE_SET      = 4'h9
   } sdt_cmd_e;

   // ****************************************
   // Mode word carried on the row lines
   // ****************************************
   localparam int MF_RL_LSB     = 0;
   localparam int MF_AL_LSB     = 4;
   localparam int MF_WL_LSB     = 7;
   localparam int MF_DLL_OFF    = 11;
   localparam int MF_CHOP_FIXED = 12;
   localparam logic [ROW_W-1:0] MODE_RESET = 14'h0306;

   // ****************************************
   // Timing figures and cycle counts
   // ****************************************
   localparam longint RAS_MIN_PS      = 35000;
   localparam longint RCD_PS          = 13750;
   localparam longint RP_PS           = 13750;
   localparam longint RFC_PS          = 160000;
   localparam longint WR_PS           = 15000;
   localparam int     WR_DLL_OFF_CK   = 4;
   localparam longint XPDLL_PS        = 24000;
   localparam int     XPDLL_MIN_CK    = 10;
   localparam int     REFPDEN_MIN_CK  = 1;
   localparam longint SLOW_CLK_PS     = 40000;
   localparam longint REF_85_MS       = 64;
   localparam longint REF_95_MS       = 32;
   localparam longint REF_105_MS      = 16;
   localparam longint REF_ROWS        = 8192;
   localparam longint REF_WINDOW_PS   = 70300000;
   localparam int     REF_BURST       = 9;
   localparam longint RESET_HOLD_PS   = 200000000;
   localparam int     WR_START_FULL   = 4;
   localparam int     WR_START_CHOP   = 2;

   localparam int RAS_CYC        = cyc_min(RAS_MIN_PS);
   localparam int RCD_CYC        = cyc_min(RCD_PS);
   localparam int RP_CYC         = cyc_min(RP_PS);
   localparam int RFC_CYC        = cyc_min(RFC_PS);
   localparam int WR_CYC         = cyc_min(WR_PS);
   localparam int WR_DLL_OFF_CYC = (WR_CYC > WR_DLL_OFF_CK) ? WR_CYC : WR_DLL_OFF_CK;
   localparam int XPDLL_CYC      = (cyc_min(XPDLL_PS) > XPDLL_MIN_CK) ? cyc_min(XPDLL_PS) : XPDLL_MIN_CK;
   localparam int REFI_85_CYC    = cyc_max(REF_85_MS * 64'd1000000000 / REF_ROWS);
   localparam int REFI_95_CYC    = cyc_max(REF_95_MS * 64'd1000000000 / REF_ROWS);
   localparam int REFI_105_CYC   = cyc_max(REF_105_MS * 64'd1000000000 / REF_ROWS);
   localparam int REF_WINDOW_CYC = cyc_max(REF_WINDOW_PS);
   localparam int RESET_HOLD_CYC = cyc_min(RESET_HOLD_PS);
   localparam bit SLOW_CLK       = (CLK_PS > SLOW_CLK_PS);

   localparam logic [1:0] TEMP_85  = 2'h0;
   localparam logic [1:0] TEMP_95  = 2'h1;
   localparam logic [1:0] TEMP_105 = 2'h2;

endpackage : sdt_pkg

// ==== sim/sdt_assertions.sv ====
`timescale 1ns/100ps
module sdt_assertions
   import sdt_pkg::*;
#(
   parameter int REF_WINDOW = REF_WINDOW_CYC
) (
   // Clock and reset
   input wire logic             SYS_CLK,
   input wire logic             SYS_RST,
   // Command link
   input wire sdt_cmd_e         cmd,
   input wire logic [ROW_W-1:0] row,
   input wire logic             cke,
   input wire logic             reset_n,
   input wire logic             dq_dev_oe
);
   // ****************
   // Trackers
   // ****************
   logic [31:0] hist;
   logic [4:0]  lat;
   logic [15:0] ref_age;
   logic [7:0]  lock_age;
   logic        cke_q;
   // Ages saturate so a long idle stretch cannot wrap into a false pass
   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         hist     <= '0;
         lat      <= 5'h06;
         ref_age  <= '0;
         lock_age <= '0;
         cke_q    <= 1'b0;
      end else begin
         hist     <= {hist[30:0], cmd inside {CMD_READ, CMD_READ_AP}};
         lat      <= (cmd == CMD_MODE_SET) ? 5'(row[3:0]) + 5'(row[6:4]) - 5'(row[MF_DLL_OFF]) : lat;
         ref_age  <= (cmd == CMD_REFRESH) ? '0 : ref_age + 16'(ref_age != 16'hFFFF);
         lock_age <= (cmd == CMD_MODE_SET || (cke && !cke_q)) ? '0 : lock_age + 8'(lock_age != 8'hFF);
         cke_q    <= cke;
      end
   end
   // ****************
   // Properties
   // ****************
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (SYS_RST);
   refresh_idle_a: assert property (cmd == CMD_REFRESH |=> (cmd == CMD_NOP) [*8])
      else $error("refresh not followed by idle cycles");
   act_spacing_a: assert property (cmd == CMD_ACTIVATE |=> (cmd == CMD_NOP) [*2] ##1
      (cmd inside {CMD_READ, CMD_READ_AP, CMD_WRITE, CMD_WRITE_AP})) else $error("access spacing off");
   row_hold_a: assert property (cmd == CMD_ACTIVATE |=> (cmd != CMD_PRECHARGE) [*6])
      else $error("precharge too early");
   reset_quiet_a: assert property (!reset_n |-> cmd == CMD_NOP && !cke)
      else $error("activity while device held in reset");
   reset_exit_a: assert property ($rose(reset_n) |-> cmd == CMD_MODE_SET && row == MODE_RESET && cke)
      else $error("wrong first command after reset");
   read_window_a: assert property (dq_dev_oe == hist[lat - 5'h01])
      else $error("read window at wrong cycle");
   pd_entry_a: assert property ($fell(cke) && reset_n |-> ref_age >= XPDLL_CYC)
      else $error("power down too soon after refresh");
   read_lock_a: assert property (cmd inside {CMD_READ, CMD_READ_AP} |-> lock_age >= XPDLL_CYC)
      else $error("read before exit delay");
   refresh_window_a: assert property (ref_age < REF_WINDOW)
      else $error("refresh postponed too long");
endmodule : sdt_assertions

// ==== sim/testbench.sv ====
`timescale 1ns/100ps
module testbench;
   import sdt_pkg::*;
   logic SYS_CLK, SYS_RST, rv, rw, rap, rch, mv, pd, rdy, pda, rdv, rwin, ap, terr;
   logic [2:0]  bk;
   logic [13:0] rrow, mw;
   logic [1:0]  temp;
   logic [7:0]  rdd, bo;
   int          n_mismatch, num_checks, cycles, n_rd;
   sdt_if bus();
   sdt_ctrl #(.RESET_HOLD(8)) u_sdt_ctrl (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .REQ_VALID(rv),
      .REQ_READY(rdy), .REQ_WRITE(rw), .REQ_AUTO_PRE(rap), .REQ_OTF_CHOP(rch), .REQ_BANK(bk),
      .REQ_ROW(rrow), .MODE_VALID(mv), .MODE_WORD(mw), .TEMP_RANGE(temp), .PD_REQ(pd),
      .PD_ACTIVE(pda), .RD_VALID(rdv), .RD_DATA(rdd), .mem(bus));
   sdt_dev u_sdt_dev (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .mem(bus), .BANK_OPEN(bo),
      .RD_WINDOW(rwin), .AUTO_PRE(ap), .TIMING_ERR(terr));
   sdt_assertions chk (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .cmd(bus.cmd), .row(bus.row),
      .cke(bus.cke), .reset_n(bus.reset_n), .dq_dev_oe(bus.dq_dev_oe));
   // ****************
   // Helpers
   // ****************
   task automatic step();
      @(posedge SYS_CLK);
      #1;
   endtask : step
   task automatic check(input logic ok, input string msg);
      num_checks++;
      if (ok !== 1'b1) begin
         n_mismatch++;
         $display("wrong value at %0t: %s", $time, msg);
      end
   endtask : check
   task automatic wait_cmd(input sdt_cmd_e c, input int lim, output int n);
      n = 0;
      while (bus.cmd !== c && n < lim) begin
         step();
         n++;
      end
      check(n < lim, "command never seen");
   endtask : wait_cmd
   task automatic results();
      if (n_mismatch == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : results
   // Runs one access with auto precharge; times are counted from its ACTIVATE
   task automatic access(input logic wr, input logic chop, input logic [2:0] b, output int t_rw,
                         output int t_win, output int t_ap);
      int n, t_rv;
      {rw, rap, rch, bk, rrow, rv} = {wr, 1'b1, chop, b, 14'h0123 + 14'(b), 1'b1};
      n = 0;
      while (rdy !== 1'b1 && n < 2000) begin
         step();
         n++;
      end
      step();
      rv = 1'b0;
      wait_cmd(CMD_ACTIVATE, 5, n);
      check(bus.row === (rrow ^ (14'(b) << 11)), "activate row");
      {t_rw, t_win, t_ap} = '0;
      for (int i = 1; i < 40; i++) begin
         step();
         if (bus.cmd inside {CMD_READ_AP, CMD_WRITE_AP}) t_rw = i;
         if (rwin === 1'b1) t_win = i;
         if (ap === 1'b1) t_ap = i;
         if (rdv === 1'b1) begin
            t_rv = i;
            check(rdd === 8'(n_rd), "read data");
         end
      end
      if (!wr) begin
         check(t_rv == t_win + 1, "read valid");
         n_rd++;
      end
      check(t_rw == RCD_CYC, "access command spacing");
      check(bo === 8'h00, "bank left open");
   endtask : access
   // ****************
   // Scenarios
   // ****************
   task automatic t_reset();
      int n;
      wait_cmd(CMD_MODE_SET, 40, n);
      check(bus.row === MODE_RESET && bus.reset_n === 1'b1, "reset exit");
   endtask : t_reset
   task automatic t_modes();
      logic [13:0] w [5] = '{14'h0306, 14'h0306, 14'h1306, 14'h0B06, 14'h0326};
      int n, a, b, c, dll, ew;
      for (int i = 0; i < 5; i++) begin
         {mw, mv} = {w[i], 1'b1};
         step();
         mv = 1'b0;
         wait_cmd(CMD_MODE_SET, 200, n);
         dll = w[i][MF_DLL_OFF];
         // Precharge pulse is registered, so it shows one cycle late
         ew = RCD_CYC + 1 + w[i][10:7] + (w[i][MF_CHOP_FIXED] ? WR_START_CHOP : WR_START_FULL);
         access(1'b1, i == 1, 3'(i), a, b, c);
         check(c == ew + (dll ? WR_DLL_OFF_CYC : WR_CYC), "write recovery");
         access(1'b0, 1'b0, 3'(i), a, b, c);
         check(b - a == w[i][3:0] + w[i][6:4] - dll, "read latency");
         check(c == RAS_CYC + 1, "auto precharge hold");
      end
   endtask : t_modes
   task automatic t_refresh();
      int iv [3] = '{REFI_85_CYC, REFI_95_CYC, REFI_105_CYC};
      int n;
      for (int t = 0; t < 3; t++) begin
         temp = 2'(t);
         repeat (3) begin
            wait_cmd(CMD_REFRESH, 2000, n);
            step();
         end
         check(n + 1 == iv[t], "refresh interval");
      end
   endtask : t_refresh
   task automatic t_pd();
      int n, a, b, c;
      pd = 1'b1;
      while (bus.cke !== 1'b0 && n < 100) begin
         step();
         n++;
      end
      check(pda === 1'b1 && n < 100, "power down entry");
      wait_cmd(CMD_REFRESH, 4000, n);
      check(bus.cke === 1'b1, "forced refresh wakes");
      pd = 1'b0;
      access(1'b0, 1'b0, 3'h5, a, b, c);
   endtask : t_pd
   initial begin
      SYS_CLK = 1'b0;
      forever #2.5 SYS_CLK = ~SYS_CLK;
   end
   always @(posedge SYS_CLK) begin
      cycles++;
      if (cycles == 60000) begin
         n_mismatch++;
         results();
      end
   end
   initial begin
      {SYS_RST, rv, rw, rap, rch, mv, pd, bk, rrow, mw, temp} = '0;
      SYS_RST = 1'b1;
      repeat (8) step();
      SYS_RST = 1'b0;
      t_reset();
      t_modes();
      t_refresh();
      t_pd();
      check(terr === 1'b0, "device timing fault");
      SYS_RST = 1'b1;
      step();
      SYS_RST = 1'b0;
      t_reset();
      results();
   end
endmodule : testbench
